// ---- hw/frc_cfg.svh ----
// Register offsets, field positions, reset values and timing for the fault router.
`ifndef FRC_CFG_SVH
`define FRC_CFG_SVH

`define FRC_OFF_CTRL 8'h00
`define FRC_OFF_STATUS 8'h04
`define FRC_OFF_EXTCFG 8'h08
`define FRC_OFF_SRCSTAT 8'h0c
`define FRC_OFF_DCMP 8'h10
`define FRC_OFF_ACMP 8'h20
`define FRC_OFF_MAXCNT 8'h40
`define FRC_OFF_MASK 8'h80

`define FRC_CTRL_FAULT_EN 0
`define FRC_CTRL_CBC_EN_LSB 8
`define FRC_CTRL_MATCH_B_LSB 12
`define FRC_EXT_POL_LSB 8
`define FRC_DCMP_SEL_LSB 16
`define FRC_DCMP_EN_BIT 20
`define FRC_ACMP_EN_BIT 16
`define FRC_SRC_ACMP_LSB 8
`define FRC_SRC_EXT_LSB 16
`define FRC_SRC_OSC_LSB 24

`define FRC_RST_WORD 32'h0000_0000

`define FRC_CLK_PERIOD_NS 40
`define FRC_OSC_FAIL_TIME_NS 10000

`endif

// ---- hw/frc_pkg.sv ----
// Types shared by the fault router.
package frc_pkg;
    // Position of a fault module inside its channel.
    typedef enum {FRC_CBC_MOD, FRC_AB_MOD, FRC_A_MOD, FRC_B_MOD} frc_kind_t;
    // Per-channel fault source order inside the event vector.
    typedef enum {FRC_SRC_CUR, FRC_SRC_OV, FRC_SRC_EXTA, FRC_SRC_EXTB, FRC_SRC_IDE,
                  FRC_SRC_COUNT} frc_chsrc_t;
endpackage

// ---- hw/frc_top.sv ----
// Fault routing, fault counting and cycle-by-cycle limiting for the pulse modulator channels.
//
// Chosen here: the address map and the Avalon-MM register port.
`include "frc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module frc_top #(
    parameter int N_CH = 4,
    parameter int N_FE = 3,
    parameter int ERR_W = 10,
    parameter int N_DCMP = 4,
    parameter int N_ACMP = 7,
    parameter int ACMP_W = 7,
    parameter int N_EXT = 4,
    parameter int CNT_W = 8
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Register bus.
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Front end results and comparator pins.
    input wire logic [N_FE*ERR_W-1:0] error_converter_result,
    input wire logic [N_ACMP-1:0] acmp_trip_pin,
    output logic [N_ACMP*ACMP_W-1:0] acmp_threshold,
    input wire logic [N_EXT-1:0] ext_fault_pin,
    input wire logic [1:0] osc_probe_pin,
    // Channel side.
    input wire logic [N_CH-1:0] channel_output_enable,
    input wire logic [N_CH-1:0] cycle_start,
    input wire logic [N_CH-1:0] conduction_a,
    input wire logic [N_CH-1:0] cur_limit_fault,
    input wire logic [N_CH-1:0] over_volt_fault,
    input wire logic [N_CH-1:0] ext_fault_a,
    input wire logic [N_CH-1:0] ext_fault_b,
    input wire logic [N_CH-1:0] diode_emulation_flag,
    input wire logic [N_CH-1:0] zero_cross,
    input wire logic [N_CH-1:0] pcm_trip_pin,
    // Responses to the channels.
    output logic [4*N_CH-1:0] fault_flag,
    output logic [N_CH-1:0] shutdown_a,
    output logic [N_CH-1:0] shutdown_b,
    output logic [N_CH-1:0] per_cycle_limit_end_a,
    output logic [N_CH-1:0] per_cycle_limit_end_b
);
    localparam int NM = 4 * N_CH;
    localparam int NSRC = int'(frc_pkg::FRC_SRC_COUNT);
    localparam int EV_W = N_DCMP + N_ACMP + N_EXT + NSRC * N_CH + 2 + N_CH;
    localparam int A_W = N_ACMP + N_EXT + 2 + N_CH;
    localparam int OSC_TO = `FRC_OSC_FAIL_TIME_NS / `FRC_CLK_PERIOD_NS;
    localparam logic [15:0] OSC_TO_C = 16'(OSC_TO);
    localparam logic [5:0] W_CTRL = 6'(`FRC_OFF_CTRL >> 2);
    localparam logic [5:0] W_STATUS = 6'(`FRC_OFF_STATUS >> 2);
    localparam logic [5:0] W_EXTCFG = 6'(`FRC_OFF_EXTCFG >> 2);
    localparam logic [5:0] W_SRCSTAT = 6'(`FRC_OFF_SRCSTAT >> 2);
    localparam logic [5:0] W_DCMP = 6'(`FRC_OFF_DCMP >> 2);
    localparam logic [5:0] W_ACMP = 6'(`FRC_OFF_ACMP >> 2);
    localparam logic [5:0] W_MAXCNT = 6'(`FRC_OFF_MAXCNT >> 2);
    localparam logic [5:0] W_MASK = 6'(`FRC_OFF_MASK >> 2);

    if (N_CH < 1 || N_CH > 4 || N_DCMP > 4 || N_ACMP > 8 || N_EXT > 8 || EV_W > 64
        || ACMP_W > 16 || ERR_W > 16 || CNT_W > 16 || N_FE < 1 || N_FE > 4) begin : g_bad
        $error("frc_top: parameter values outside the supported range");
    end

    function automatic logic [31:0] frc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Bus handshake: every access waits exactly one cycle so read data can come from a flop.
    logic ack_reg;
    logic [31:0] rdata_reg;
    wire logic req = avs_read | avs_write;
    wire logic wr_en = avs_write & ack_reg;
    wire logic [5:0] widx = avs_address[7:2];
    wire logic [31:0] rd_mux;
    assign avs_waitrequest = req & ~ack_reg;
    assign avs_readdata = rdata_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= `FRC_RST_WORD;
        end else begin
            ack_reg <= req & ~ack_reg;
            rdata_reg <= rd_mux;
        end
    end

    // Control registers.
    logic [31:0] ctrl_reg;
    logic [31:0] extcfg_reg;
    wire logic hit_ctrl = widx == W_CTRL;
    wire logic hit_ext = widx == W_EXTCFG;
    wire logic fault_en = ctrl_reg[`FRC_CTRL_FAULT_EN];
    wire logic [N_CH-1:0] cbc_en = ctrl_reg[`FRC_CTRL_CBC_EN_LSB +: N_CH];
    wire logic [N_CH-1:0] match_b = ctrl_reg[`FRC_CTRL_MATCH_B_LSB +: N_CH];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `FRC_RST_WORD;
            extcfg_reg <= `FRC_RST_WORD;
        end else begin
            if (wr_en && hit_ctrl) begin
                ctrl_reg <= frc_merge(ctrl_reg, avs_writedata, avs_byteenable);
            end
            if (wr_en && hit_ext) begin
                extcfg_reg <= frc_merge(extcfg_reg, avs_writedata, avs_byteenable);
            end
        end
    end

    // Pins from other domains pass two flops before any use.
    logic [A_W-1:0] sync1_reg;
    logic [A_W-1:0] sync2_reg;
    logic [1:0] osc_prev_reg;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            osc_prev_reg <= '0;
        end else begin
            sync1_reg <= {pcm_trip_pin, osc_probe_pin, ext_fault_pin, acmp_trip_pin};
            sync2_reg <= sync1_reg;
            osc_prev_reg <= sync2_reg[N_ACMP+N_EXT +: 2];
        end
    end
    wire logic [N_ACMP-1:0] acmp_s = sync2_reg[0 +: N_ACMP];
    wire logic [N_EXT-1:0] ext_s = sync2_reg[N_ACMP +: N_EXT];
    wire logic [1:0] osc_s = sync2_reg[N_ACMP+N_EXT +: 2];
    wire logic [N_CH-1:0] pcm_s = sync2_reg[N_ACMP+N_EXT+2 +: N_CH];

    // External pins with per-pin enable and polarity.
    wire logic [N_EXT-1:0] ext_ev = (ext_s ^ extcfg_reg[`FRC_EXT_POL_LSB +: N_EXT])
                                  & extcfg_reg[0 +: N_EXT];

    // Digital comparators on the error converter results.
    logic [ERR_W-1:0] fe_res [4];
    logic [N_DCMP*32-1:0] dcmp_all;
    wire logic [N_DCMP-1:0] dcmp_ev;
    for (genvar f = 0; f < 4; f++) begin : g_fe
        if (f < N_FE) begin : g_on
            assign fe_res[f] = error_converter_result[f*ERR_W +: ERR_W];
        end else begin : g_off
            assign fe_res[f] = '0;
        end
    end
    for (genvar d = 0; d < N_DCMP; d++) begin : g_dcmp
        logic [31:0] cfg_reg;
        wire logic [1:0] sel = cfg_reg[`FRC_DCMP_SEL_LSB +: 2];
        wire logic above = $signed(fe_res[sel]) > $signed(cfg_reg[ERR_W-1:0]);
        assign dcmp_ev[d] = above & cfg_reg[`FRC_DCMP_EN_BIT];
        assign dcmp_all[d*32 +: 32] = cfg_reg;
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                cfg_reg <= `FRC_RST_WORD;
            end else if (wr_en && widx == W_DCMP + 6'(d)) begin
                cfg_reg <= frc_merge(cfg_reg, avs_writedata, avs_byteenable);
            end
        end
    end

    // Analog comparators: the threshold goes out, the trip comes back on a pin.
    logic [N_ACMP*32-1:0] acmp_all;
    wire logic [N_ACMP-1:0] acmp_ev;
    for (genvar k = 0; k < N_ACMP; k++) begin : g_acmp
        logic [31:0] cfg_reg;
        assign acmp_threshold[k*ACMP_W +: ACMP_W] = cfg_reg[ACMP_W-1:0];
        assign acmp_ev[k] = acmp_s[k] & cfg_reg[`FRC_ACMP_EN_BIT];
        assign acmp_all[k*32 +: 32] = cfg_reg;
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                cfg_reg <= `FRC_RST_WORD;
            end else if (wr_en && widx == W_ACMP + 6'(k)) begin
                cfg_reg <= frc_merge(cfg_reg, avs_writedata, avs_byteenable);
            end
        end
    end

    // Oscillator watch: no edge on the probe for the timeout means the oscillator died.
    wire logic [1:0] osc_fail;
    for (genvar o = 0; o < 2; o++) begin : g_osc
        logic [15:0] idle_reg;
        wire logic edge_seen = osc_s[o] ^ osc_prev_reg[o];
        assign osc_fail[o] = idle_reg == OSC_TO_C;
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                idle_reg <= '0;
            end else if (edge_seen) begin
                idle_reg <= '0;
            end else if (!osc_fail[o]) begin
                idle_reg <= idle_reg + 16'h0001;
            end
        end
    end

    // Per-channel sources, discontinuous conduction and the cycle-by-cycle block.
    wire logic [NSRC*N_CH-1:0] ch_src;
    wire logic [N_CH-1:0] dcm_ev;
    wire logic [N_CH-1:0] cbc_trip;
    logic [N_CH-1:0] end_a_reg;
    logic [N_CH-1:0] end_b_reg;
    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        assign ch_src[c*NSRC + int'(frc_pkg::FRC_SRC_CUR)] = cur_limit_fault[c];
        assign ch_src[c*NSRC + int'(frc_pkg::FRC_SRC_OV)] = over_volt_fault[c];
        assign ch_src[c*NSRC + int'(frc_pkg::FRC_SRC_EXTA)] = ext_fault_a[c];
        assign ch_src[c*NSRC + int'(frc_pkg::FRC_SRC_EXTB)] = ext_fault_b[c];
        assign ch_src[c*NSRC + int'(frc_pkg::FRC_SRC_IDE)] = diode_emulation_flag[c];
        // Inductor current reaching zero while the channel runs marks discontinuous conduction.
        assign dcm_ev[c] = zero_cross[c] & channel_output_enable[c];
        // Only trips inside the conduction time count, so ringing after turn-off is ignored.
        assign cbc_trip[c] = pcm_s[c] & conduction_a[c] & cbc_en[c];
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            end_a_reg <= '0;
            end_b_reg <= '0;
        end else begin
            end_a_reg <= cbc_trip;
            end_b_reg <= cbc_trip & match_b;
        end
    end
    assign per_cycle_limit_end_a = end_a_reg;
    assign per_cycle_limit_end_b = end_b_reg;

    // Every event the router can steer; each module selects any subset of it.
    wire logic [EV_W-1:0] ev_all = {dcm_ev, osc_fail, ch_src, ext_ev, acmp_ev, dcmp_ev};

    // Fault modules, four per channel, from the same logic; only the per-cycle-limit module also takes the channel's cycle-by-cycle trip.
    logic [NM*64-1:0] mask_all;
    logic [NM*CNT_W-1:0] maxcnt_all;
    wire logic [NM-1:0] flag_w;
    for (genvar m = 0; m < NM; m++) begin : g_fm
        localparam int CH = m / 4;
        localparam int KIND = m % 4;
        localparam bit IS_CBC = KIND == int'(frc_pkg::FRC_CBC_MOD);
        logic [31:0] mask_lo_reg;
        logic [31:0] mask_hi_reg;
        logic [CNT_W-1:0] max_reg;
        logic [CNT_W-1:0] cnt_reg;
        logic det_reg;
        logic flag_reg;
        wire logic [63:0] msk = {mask_hi_reg, mask_lo_reg};
        wire logic src_hit = |(ev_all & msk[EV_W-1:0]);
        wire logic cbc_hit = IS_CBC & cbc_trip[CH];
        wire logic hit = fault_en & (src_hit | cbc_hit);
        wire logic cyc = cycle_start[CH];
        wire logic new_hit = hit & (cyc | ~det_reg);
        wire logic det_next = cyc ? new_hit : (det_reg | new_hit);
        wire logic [CNT_W-1:0] cnt_base = (cyc & ~det_reg) ? '0 : cnt_reg;
        wire logic [CNT_W-1:0] cnt_next = (new_hit & ~&cnt_base) ? cnt_base + 1'b1 : cnt_base;
        wire logic flag_next = flag_reg | (cnt_next > max_reg);
        assign flag_w[m] = flag_reg;
        assign mask_all[m*64 +: 64] = msk;
        assign maxcnt_all[m*CNT_W +: CNT_W] = max_reg;
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                mask_lo_reg <= `FRC_RST_WORD;
                mask_hi_reg <= `FRC_RST_WORD;
                max_reg <= '0;
            end else begin
                if (wr_en && widx == W_MASK + 6'(2*m)) begin
                    mask_lo_reg <= frc_merge(mask_lo_reg, avs_writedata, avs_byteenable);
                end
                if (wr_en && widx == W_MASK + 6'(2*m+1)) begin
                    mask_hi_reg <= frc_merge(mask_hi_reg, avs_writedata, avs_byteenable);
                end
                if (wr_en && widx == W_MAXCNT + 6'(m)) begin
                    max_reg <= CNT_W'(frc_merge(32'(max_reg), avs_writedata, avs_byteenable));
                end
            end
        end
        // Besides reset, the shared channel enable is the only way out of a latched fault.
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                cnt_reg <= '0;
                det_reg <= 1'b0;
                flag_reg <= 1'b0;
            end else if (!channel_output_enable[CH]) begin
                cnt_reg <= '0;
                det_reg <= 1'b0;
                flag_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_next;
                det_reg <= det_next;
                flag_reg <= flag_next;
            end
        end
    end

    // Output shutdowns: the per-cycle-limit and both-outputs modules hit A and B alike.
    logic [N_CH-1:0] shut_a_reg;
    logic [N_CH-1:0] shut_b_reg;
    wire logic [N_CH-1:0] shut_a_next;
    wire logic [N_CH-1:0] shut_b_next;
    for (genvar c = 0; c < N_CH; c++) begin : g_shut
        wire logic both = flag_w[4*c + int'(frc_pkg::FRC_CBC_MOD)]
                        | flag_w[4*c + int'(frc_pkg::FRC_AB_MOD)];
        assign shut_a_next[c] = both | flag_w[4*c + int'(frc_pkg::FRC_A_MOD)];
        assign shut_b_next[c] = both | flag_w[4*c + int'(frc_pkg::FRC_B_MOD)];
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shut_a_reg <= '0;
            shut_b_reg <= '0;
        end else begin
            shut_a_reg <= shut_a_next;
            shut_b_reg <= shut_b_next;
        end
    end
    assign shutdown_a = shut_a_reg;
    assign shutdown_b = shut_b_reg;
    assign fault_flag = flag_w;

    // Read decode.
    wire logic hit_status = widx == W_STATUS;
    wire logic hit_src = widx == W_SRCSTAT;
    wire logic hit_dcmp = widx >= W_DCMP && widx < W_DCMP + 6'(N_DCMP);
    wire logic hit_acmp = widx >= W_ACMP && widx < W_ACMP + 6'(N_ACMP);
    wire logic hit_max = widx >= W_MAXCNT && widx < W_MAXCNT + 6'(NM);
    wire logic hit_mask = widx >= W_MASK && widx < W_MASK + 6'(2*NM);
    wire logic [5:0] off_dcmp = widx - W_DCMP;
    wire logic [5:0] off_acmp = widx - W_ACMP;
    wire logic [5:0] off_max = widx - W_MAXCNT;
    wire logic [5:0] off_mask = widx - W_MASK;
    wire logic [31:0] src_word = 32'(dcmp_ev) | (32'(acmp_ev) << `FRC_SRC_ACMP_LSB)
                               | (32'(ext_ev) << `FRC_SRC_EXT_LSB)
                               | (32'(osc_fail) << `FRC_SRC_OSC_LSB);
    assign rd_mux = !avs_read ? '0 :
                    hit_ctrl ? ctrl_reg :
                    hit_status ? 32'(flag_w) :
                    hit_ext ? extcfg_reg :
                    hit_src ? src_word :
                    hit_dcmp ? dcmp_all[off_dcmp*32 +: 32] :
                    hit_acmp ? acmp_all[off_acmp*32 +: 32] :
                    hit_max ? 32'(maxcnt_all[off_max*CNT_W +: CNT_W]) :
                    hit_mask ? mask_all[off_mask*32 +: 32] : '0;

endmodule // frc_top

`default_nettype wire

// ---- test/frc_chan_model.sv ----
// Behavioural pulse modulator channels facing the fault router.
`timescale 1ns/1ps
`default_nettype none

module frc_chan_model #(
    parameter int N_CH = 4,
    parameter int PERIOD = 16
) (
    // Clock, reset and bench control.
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [N_CH-1:0] run,
    // Fault router side.
    input wire logic [N_CH-1:0] per_cycle_limit_end_a,
    output logic [N_CH-1:0] channel_output_enable,
    output logic [N_CH-1:0] cycle_start,
    output logic [N_CH-1:0] conduction_a
);
    int phase;
    logic last;
    logic [N_CH-1:0] cond_next;
    assign last = (phase == PERIOD - 1);
    // Once the pulse is cut short, A stays off until the next period.
    assign cond_next = last ? run : conduction_a & ~per_cycle_limit_end_a
                                  & {N_CH{phase < PERIOD / 2 - 1}};
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase <= 0;
            channel_output_enable <= '0;
            cycle_start <= '0;
            conduction_a <= '0;
        end else begin
            phase <= last ? 0 : phase + 1;
            channel_output_enable <= run;
            cycle_start <= run & {N_CH{last}};
            conduction_a <= cond_next;
        end
    end
endmodule // frc_chan_model

`default_nettype wire

// ---- test/frc_top_chk.sv ----
// Concurrent checks on the fault router ports.
`timescale 1ns/1ps
`default_nettype none

module frc_top_chk #(
    parameter int N_CH = 4
) (
    // Clock, reset and bus handshake.
    input wire logic core_clk,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Channel side.
    input wire logic [N_CH-1:0] channel_output_enable,
    input wire logic [N_CH-1:0] conduction_a,
    input wire logic [N_CH-1:0] pcm_trip_pin,
    input wire logic [4*N_CH-1:0] fault_flag,
    input wire logic [N_CH-1:0] shutdown_a,
    input wire logic [N_CH-1:0] shutdown_b,
    input wire logic [N_CH-1:0] per_cycle_limit_end_a,
    input wire logic [N_CH-1:0] per_cycle_limit_end_b
);
    logic [4*N_CH-1:0] en_rep;
    logic [N_CH-1:0] a_src;
    logic [N_CH-1:0] b_src;
    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        assign en_rep[4*c+3:4*c] = {4{channel_output_enable[c]}};
        assign a_src[c] = (fault_flag[4*c+1] | fault_flag[4*c+2]) & channel_output_enable[c];
        assign b_src[c] = (fault_flag[4*c+1] | fault_flag[4*c+3]) & channel_output_enable[c];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_WAIT_FIRST: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
        else $error("first request cycle did not wait");
    AST_WAIT_ONE: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request waited more than one cycle");
    AST_FLAG_HOLD: assert property ((fault_flag & en_rep) != '0 |=>
        (fault_flag & $past(fault_flag & en_rep)) == $past(fault_flag & en_rep))
        else $error("flag dropped while channel enabled");
    AST_FLAG_CLEAR: assert property ((fault_flag & ~$past(en_rep)) == '0)
        else $error("flag not cleared by channel disable");
    AST_SHUT_A: assert property ((shutdown_a & $past(a_src)) == $past(a_src))
        else $error("output a not shut down after flag");
    AST_SHUT_B: assert property ((shutdown_b & $past(b_src)) == $past(b_src))
        else $error("output b not shut down after flag");
    AST_END_COND: assert property ((per_cycle_limit_end_a & ~$past(conduction_a)) == '0)
        else $error("early end outside conduction");
    AST_END_TRIP: assert property ((per_cycle_limit_end_a & ~$past(pcm_trip_pin, 3)) == '0)
        else $error("early end without peak trip");
    AST_END_B: assert property ((per_cycle_limit_end_b & ~per_cycle_limit_end_a) == '0)
        else $error("early end on b without a");
    CV_FLAG: cover property (fault_flag != '0);
    CV_END: cover property (per_cycle_limit_end_b != '0);
    CV_SHUT: cover property (shutdown_a != '0 && shutdown_b != '0);
endmodule // frc_top_chk

`default_nettype wire

// ---- test/test_fault_routing_and_counting.sv ----
// Self-checking bench for the fault router.
`timescale 1ns/1ps
`default_nettype none

module test_fault_routing_and_counting;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest;
    logic [29:0] error_converter_result = 30'h0;
    logic [6:0] acmp_trip_pin = 7'h0;
    logic [48:0] acmp_threshold;
    logic [1:0] osc_probe_pin = 2'h0;
    logic [3:0] run = 4'h0, over_volt_fault = 4'h0, pcm_trip_pin = 4'h0, ext_fault_pin = 4'h0;
    logic [3:0] cur_limit_fault = 4'h0, zero_cross = 4'h0;
    logic [3:0] channel_output_enable, cycle_start, conduction_a, shutdown_a, shutdown_b;
    logic [3:0] per_cycle_limit_end_a, per_cycle_limit_end_b;
    logic [15:0] fault_flag;
    int error_cnt = 0, tests_run = 0;

    always #20 core_clk = ~core_clk;

    frc_top dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .error_converter_result(error_converter_result),
        .acmp_trip_pin(acmp_trip_pin), .acmp_threshold(acmp_threshold),
        .ext_fault_pin(ext_fault_pin), .osc_probe_pin(osc_probe_pin),
        .channel_output_enable(channel_output_enable), .cycle_start(cycle_start),
        .conduction_a(conduction_a), .cur_limit_fault(cur_limit_fault), .ext_fault_a(4'h0),
        .over_volt_fault(over_volt_fault), .ext_fault_b(4'h0), .zero_cross(zero_cross),
        .diode_emulation_flag(4'h0),
        .pcm_trip_pin(pcm_trip_pin), .fault_flag(fault_flag), .shutdown_a(shutdown_a),
        .shutdown_b(shutdown_b), .per_cycle_limit_end_a(per_cycle_limit_end_a),
        .per_cycle_limit_end_b(per_cycle_limit_end_b));

    frc_chan_model #(.N_CH(4), .PERIOD(16)) u_chan (.core_clk(core_clk), .rst(rst), .run(run),
        .per_cycle_limit_end_a(per_cycle_limit_end_a), .cycle_start(cycle_start),
        .channel_output_enable(channel_output_enable), .conduction_a(conduction_a));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Sampled at the rising edge, before the slave's flops move; waits as long as it takes.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be);
        logic busy;
        int n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= ~w;
        do begin
            @(posedge core_clk);
            busy = avs_waitrequest;
            rd = avs_readdata;
            n++;
        end while (busy);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        check("wait states", 32'h2, n);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        check(what, exp, rd);
    endtask

    task automatic wait_cs();
        int n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (cycle_start[0] !== 1'b1 && n < 40);
    endtask

    task automatic pulse();
        wait_cs();
        repeat (2) @(posedge core_clk);
        over_volt_fault <= 4'h1;
        repeat (3) @(posedge core_clk);
        over_volt_fault <= 4'h0;
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    task automatic restart();
        @(posedge core_clk);
        run <= 4'h0;
        settle(4);
        check("outputs while stopped", 32'h0, {8'h0, shutdown_b, shutdown_a, fault_flag});
        @(posedge core_clk);
        run <= 4'hf;
    endtask

    task automatic t_reg();
        rd_chk("control after reset", 8'h00, 32'h0);
        wr(8'h54, 32'hffff_ffff);
        rd_chk("limit width", 8'h54, 32'h0000_00ff);
        wr(8'h3c, 32'hffff_ffff);
        rd_chk("unmapped", 8'h3c, 32'h0);
        wr(8'h04, 32'hffff_ffff);
        rd_chk("status after write", 8'h04, 32'h0);
        bus(1'b1, 8'h08, 32'h0000_0f0f, 4'h2);
        rd_chk("lane write", 8'h08, 32'h0000_0f00);
    endtask

    task automatic t_count();
        wr(8'h90, 32'h0001_0000);
        wr(8'h48, 32'h0000_0002);
        wr(8'h00, 32'h0000_0001);
        restart();
        pulse();
        pulse();
        settle(1);
        check("flag after two cycles", 32'h0, {16'h0, fault_flag});
        pulse();
        settle(2);
        check("flag after three cycles", 32'h0000_0004, {16'h0, fault_flag});
        check("shutdowns", 32'h0000_0001, {24'h0, shutdown_b, shutdown_a});
        restart();
        pulse();
        pulse();
        wait_cs();
        pulse();
        pulse();
        settle(2);
        check("flag after gap", 32'h0, {16'h0, fault_flag});
        pulse();
        settle(2);
        check("flag after gap run", 32'h0000_0004, {16'h0, fault_flag});
    endtask

    task automatic t_many();
        wr(8'h00, 32'h0);
        restart();
        wr(8'h10, 32'h0010_0010);
        wr(8'hb8, 32'h0000_0001);
        wr(8'hc8, 32'h0000_0001);
        wr(8'hf0, 32'h0000_0811);
        error_converter_result <= 30'h11;
        settle(40);
        check("flags with enable off", 32'h0, {16'h0, fault_flag});
        bus(1'b0, 8'h0c, 32'h0, 4'hf);
        check("above threshold", 32'h1, rd & 32'h1);
        error_converter_result <= 30'h10;
        bus(1'b0, 8'h0c, 32'h0, 4'hf);
        check("at threshold", 32'h0, rd & 32'h1);
        wr(8'h00, 32'h0000_0001);
        error_converter_result <= 30'h11;
        settle(40);
        check("routed flags", 32'h0000_4280, {16'h0, fault_flag});
        check("routed shutdowns", 32'h0000_006c, {24'h0, shutdown_b, shutdown_a});
    endtask

    task automatic t_pcm();
        int n = 0;
        wr(8'h00, 32'h0000_1101);
        error_converter_result <= 30'h0;
        restart();
        wait_cs();
        @(posedge core_clk);
        pcm_trip_pin <= 4'h1;
        do begin
            settle(1);
            n++;
        end while (per_cycle_limit_end_a[0] !== 1'b1 && n < 8);
        check("early ends", 32'h3, {30'h0, per_cycle_limit_end_b[0], per_cycle_limit_end_a[0]});
        @(posedge core_clk);
        pcm_trip_pin <= 4'h0;
        settle(2);
        check("limit module flag", 32'h1, {28'h0, fault_flag[3:0]});
    endtask

    task automatic t_srcs();
        wr(8'h20, 32'h0001_0055);
        wr(8'h08, 32'h0000_0103);
        wr(8'h8c, 32'h0000_0020);
        wr(8'h98, 32'h0000_8000);
        acmp_trip_pin <= 7'h01;
        ext_fault_pin <= 4'h2;
        zero_cross <= 4'h1;
        cur_limit_fault <= 4'h1;
        repeat (6) begin
            @(posedge core_clk);
            osc_probe_pin[0] <= ~osc_probe_pin[0];
        end
        bus(1'b0, 8'h0c, 32'h0, 4'hf);
        check("source status", 32'h0203_0100, rd & 32'h030f_7f0f);
        check("threshold out", 32'h55, {25'h0, acmp_threshold[6:0]});
        check("cycle and limit flags", 32'h0000_000b, {28'h0, fault_flag[3:0]});
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_reg();
        t_count();
        t_many();
        t_pcm();
        t_srcs();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        check("watchdog", 32'h0, 32'h1);
        give_verdict();
    end
endmodule // test_fault_routing_and_counting

bind frc_top frc_top_chk #(.N_CH(N_CH)) u_chk (.core_clk(core_clk), .rst(rst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .channel_output_enable(channel_output_enable), .conduction_a(conduction_a),
    .pcm_trip_pin(pcm_trip_pin), .fault_flag(fault_flag), .shutdown_a(shutdown_a),
    .shutdown_b(shutdown_b), .per_cycle_limit_end_a(per_cycle_limit_end_a),
    .per_cycle_limit_end_b(per_cycle_limit_end_b));

`default_nettype wire
